// File: inc/psf_pkg.sv
// shared constants, types and helpers for the pressure sensor fetch link
package psf_pkg;

    // ****************************************************************
    // addressing and packet coding
    // ****************************************************************
    localparam logic [6:0] TGT_ADDR = 7'h28;
    localparam logic [1:0] STAT_GOOD = 2'h0;
    localparam logic [1:0] STAT_CMD = 2'h1;
    localparam logic [1:0] STAT_STALE = 2'h2;
    localparam logic [1:0] STAT_DIAG = 2'h3;
    localparam logic [1:0] STAT_RST = STAT_STALE;
    localparam int P_W = 14;
    localparam int T_W = 11;
    localparam int FLT_W = 4;
    localparam int MEAS_W = FLT_W + T_W + P_W;
    localparam int BITS_PER_FRAME = 9;
    localparam logic [2:0] LAST_IDX = 3'h4;

    // ****************************************************************
    // timing
    // ****************************************************************
    localparam int CLK_PERIOD_NS = 8;
    localparam int SCL_KHZ = 100;
    // quarter of an scl period, rounded down so scl never drops below 100k
    localparam int QTR_CYC = 1000000 / (SCL_KHZ * 4 * CLK_PERIOD_NS);
    localparam int T_BUF_NS = 2000;
    localparam int BUF_CYC = (T_BUF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ****************************************************************
    // state types
    // ****************************************************************
    typedef enum logic [2:0] {
        DS_IDLE = 3'h0,
        DS_ADDR = 3'h1,
        DS_AACK = 3'h2,
        DS_SEND = 3'h3,
        DS_MACK = 3'h4
    } psf_dev_state_type;

    typedef enum logic [2:0] {
        HS_IDLE = 3'h0,
        HS_START = 3'h1,
        HS_BITS = 3'h2,
        HS_HOLD = 3'h3,
        HS_STOP = 3'h4,
        HS_FREE = 3'h5
    } psf_host_state_type;

    // ****************************************************************
    // helpers
    // ****************************************************************
    // a change counts once second and third stage agree
    function automatic logic filt(input logic s2, input logic s3,
                                  input logic prev);
        filt = (s2 == s3) ? s3 : prev;
    endfunction : filt

    function automatic logic [7:0] pkt_byte(input logic [2:0] idx,
                                            input logic [1:0] stat,
                                            input logic [P_W-1:0] p,
                                            input logic [T_W-1:0] t);
        case (idx)
            3'h0: pkt_byte = {stat, p[13:8]};
            3'h1: pkt_byte = p[7:0];
            3'h2: pkt_byte = t[10:3];
            3'h3: pkt_byte = {t[2:0], 5'h00};
            default: pkt_byte = 8'h00;
        endcase
    endfunction : pkt_byte

endpackage : psf_pkg

// File: inc/psf_link_if.sv
// two-wire link between host end and sensor end, with pull-ups
`timescale 1ns/1ps
`default_nettype none
interface psf_link_if;
    logic scl_o;
    logic scl_oe;
    logic h_sda_o;
    logic h_sda_oe;
    logic d_sda_o;
    logic d_sda_oe;
    logic scl;
    logic sda;

    // open drain: a released line floats high
    assign scl = scl_oe ? scl_o : 1'b1;
    assign sda = (h_sda_oe ? h_sda_o : 1'b1) & (d_sda_oe ? d_sda_o : 1'b1);

    modport host (output scl_o, output scl_oe, output h_sda_o,
                  output h_sda_oe, input sda);
    modport dev (output d_sda_o, output d_sda_oe, input scl, input sda);
endinterface : psf_link_if
`default_nettype wire

// File: core/psf_buf.sv
// small valid/ready queue, head entry held in a flop
`timescale 1ns/1ps
`default_nettype none
module psf_buf #(
    parameter int W = 8,
    parameter int D = 2
) (
    input wire logic mclk_i,
    input wire logic sys_rst_i,
    input wire logic in_valid_i,
    input wire logic [W-1:0] in_data_i,
    output logic in_ready_o,
    output logic out_valid_o,
    output logic [W-1:0] out_data_o,
    input wire logic out_ready_i
);
    localparam int CW = $clog2(D + 1);

    logic [W-1:0] mem_r [D];
    logic [CW-1:0] cnt_r;
    logic rdy_r;
    logic vld_r;

    wire push = in_valid_i & rdy_r;
    wire pop = vld_r & out_ready_i;
    wire [CW-1:0] cnt_nxt = cnt_r + CW'(push) - CW'(pop);
    wire [CW-1:0] wr_idx = cnt_r - CW'(pop);

    assign in_ready_o = rdy_r;
    assign out_valid_o = vld_r;
    assign out_data_o = mem_r[0];

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            cnt_r <= '0;
            rdy_r <= 1'b1;
            vld_r <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            rdy_r <= (cnt_nxt != CW'(D));
            vld_r <= (cnt_nxt != '0);
        end
    end

    // shift toward the head so the output never passes a mux
    always_ff @(posedge mclk_i) begin
        for (int i = 0; i < D; i++) begin
            if (push && (wr_idx == CW'(i))) begin
                mem_r[i] <= in_data_i;
            end else if (pop && (i < D - 1)) begin
                mem_r[i] <= mem_r[(i < D - 1) ? i + 1 : i];
            end
        end
    end
endmodule : psf_buf
`default_nettype wire

// File: core/psf_dev.sv
// sensor end: answers packet fetches on the two-wire link
//
// What this block does
// - answer only our own seven-bit address
// - address plus read bit gets our acknowledge
// - keep sending bytes while master acknowledges
// - byte one status and pressure high, two low
// - third byte temperature bits ten to three
// - fourth byte temperature low three, rest masked
// - master nacks last wanted byte, then stop
// - pressure only: nack second byte, then stop
// - start then stop without clocks: error
// - repeated start mid transfer: same error
// - no sda fall between start and clock
// - status 00 fresh, 01 command, 10 stale, 11 diag
// - fetch before first result reports stale
// - any listed fault reports status 11
// - fault taken per cycle, reported next fetch
// - diagnostic status sticks until power-on reset
`timescale 1ns/1ps
`default_nettype none
module psf_dev #(
    parameter logic [6:0] ADDR = psf_pkg::TGT_ADDR,
    parameter int MQ_DEPTH = 2
) (
    input wire logic mclk_i,
    input wire logic sys_rst_i,
    input wire logic meas_valid_i,
    input wire logic [psf_pkg::P_W-1:0] meas_pressure_i,
    input wire logic [psf_pkg::T_W-1:0] meas_temp_i,
    input wire logic [psf_pkg::FLT_W-1:0] meas_fault_i,
    output logic meas_ready_o,
    input wire logic cmd_mode_i,
    output logic diag_o,
    output logic link_err_o,
    psf_link_if.dev link
);

    // ****************************************************************
    // measurement queue
    // ****************************************************************
    logic mq_valid;
    logic [psf_pkg::MEAS_W-1:0] mq_data;
    psf_pkg::psf_dev_state_type st_r;

    // results only move into the packet while the link is idle,
    // so a fetch never sees half of one cycle and half of another
    wire mq_take = mq_valid & (st_r == psf_pkg::DS_IDLE);

    psf_buf #(
        .W(psf_pkg::MEAS_W),
        .D(MQ_DEPTH)
    ) u_mq (
        .mclk_i(mclk_i),
        .sys_rst_i(sys_rst_i),
        .in_valid_i(meas_valid_i),
        .in_data_i({meas_fault_i, meas_temp_i, meas_pressure_i}),
        .in_ready_o(meas_ready_o),
        .out_valid_o(mq_valid),
        .out_data_o(mq_data),
        .out_ready_i(mq_take)
    );

    // ****************************************************************
    // pin sampling
    // ****************************************************************
    logic [2:0] scl_s_r;
    logic [2:0] sda_s_r;
    logic scl_f_r;
    logic sda_f_r;

    wire scl_f = psf_pkg::filt(scl_s_r[1], scl_s_r[2], scl_f_r);
    wire sda_f = psf_pkg::filt(sda_s_r[1], sda_s_r[2], sda_f_r);
    wire scl_rise = scl_f & ~scl_f_r;
    wire scl_fall = ~scl_f & scl_f_r;
    wire start_ev = scl_f & scl_f_r & sda_f_r & ~sda_f;
    wire stop_ev = scl_f & scl_f_r & ~sda_f_r & sda_f;

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            scl_s_r <= 3'h7;
            sda_s_r <= 3'h7;
            scl_f_r <= 1'b1;
            sda_f_r <= 1'b1;
        end else begin
            scl_s_r <= {scl_s_r[1:0], link.scl};
            sda_s_r <= {sda_s_r[1:0], link.sda};
            scl_f_r <= scl_f;
            sda_f_r <= sda_f;
        end
    end

    // ****************************************************************
    // packet and status
    // ****************************************************************
    logic [psf_pkg::P_W-1:0] p_r;
    logic [psf_pkg::T_W-1:0] t_r;
    logic fresh_r;
    logic diag_r;
    logic [1:0] stat_r;
    logic fetch;

    wire mq_fault = |mq_data[psf_pkg::MEAS_W-1 -: psf_pkg::FLT_W];
    wire [1:0] stat_now = diag_r ? psf_pkg::STAT_DIAG :
                          cmd_mode_i ? psf_pkg::STAT_CMD :
                          fresh_r ? psf_pkg::STAT_GOOD :
                          psf_pkg::STAT_STALE;

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            p_r <= '0;
            t_r <= '0;
            fresh_r <= 1'b0;
            diag_r <= 1'b0;
            stat_r <= psf_pkg::STAT_RST;
        end else begin
            if (mq_take) begin
                p_r <= mq_data[psf_pkg::P_W-1:0];
                t_r <= mq_data[psf_pkg::P_W +: psf_pkg::T_W];
                diag_r <= diag_r | mq_fault;
            end
            // a new result wins over a fetch in the same cycle
            if (mq_take) begin
                fresh_r <= 1'b1;
            end else if (fetch) begin
                fresh_r <= 1'b0;
            end
            if (fetch) begin
                stat_r <= stat_now;
            end
        end
    end

    assign diag_o = diag_r;

    // ****************************************************************
    // link state machine
    // ****************************************************************
    logic [3:0] cnt_r;
    logic [7:0] shf_r;
    logic [2:0] idx_r;
    logic sda_oe_r;
    logic ackd_r;
    logic err_r;
    logic seen_r;

    wire addr_hit = (shf_r[7:1] == ADDR) & shf_r[0];
    wire [2:0] idx_nxt = (idx_r == psf_pkg::LAST_IDX) ? idx_r : idx_r + 3'h1;
    wire [7:0] byte_first = psf_pkg::pkt_byte(3'h0, stat_r, p_r, t_r);
    wire [7:0] byte_next = psf_pkg::pkt_byte(idx_nxt, stat_r, p_r, t_r);

    assign fetch = (st_r == psf_pkg::DS_ADDR) & scl_fall &
                   (cnt_r == 4'h8) & addr_hit & ~start_ev & ~stop_ev;
    assign link.d_sda_o = 1'b0;
    assign link.d_sda_oe = sda_oe_r;
    assign link_err_o = err_r;

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            st_r <= psf_pkg::DS_IDLE;
            cnt_r <= 4'h0;
            shf_r <= 8'h00;
            idx_r <= 3'h0;
            sda_oe_r <= 1'b0;
            ackd_r <= 1'b0;
            err_r <= 1'b0;
            seen_r <= 1'b0;
        end else if (start_ev) begin
            sda_oe_r <= 1'b0;
            cnt_r <= 4'h0;
            seen_r <= 1'b0;
            if (err_r) begin
                // this start only clears the error; transfer ignored
                err_r <= 1'b0;
                st_r <= psf_pkg::DS_IDLE;
            end else if (st_r != psf_pkg::DS_IDLE) begin
                err_r <= 1'b1;
                st_r <= psf_pkg::DS_IDLE;
            end else begin
                st_r <= psf_pkg::DS_ADDR;
            end
        end else if (stop_ev) begin
            if (st_r == psf_pkg::DS_ADDR && !seen_r) begin
                err_r <= 1'b1;
            end
            st_r <= psf_pkg::DS_IDLE;
            sda_oe_r <= 1'b0;
        end else begin
            unique case (st_r)
                psf_pkg::DS_IDLE: begin
                    sda_oe_r <= 1'b0;
                end
                psf_pkg::DS_ADDR: begin
                    if (scl_rise) begin
                        shf_r <= {shf_r[6:0], sda_f};
                        cnt_r <= cnt_r + 4'h1;
                        seen_r <= 1'b1;
                    end else if (scl_fall && cnt_r == 4'h8) begin
                        if (addr_hit) begin
                            st_r <= psf_pkg::DS_AACK;
                            sda_oe_r <= 1'b1;
                        end else begin
                            st_r <= psf_pkg::DS_IDLE;
                        end
                    end
                end
                psf_pkg::DS_AACK: begin
                    if (scl_fall) begin
                        st_r <= psf_pkg::DS_SEND;
                        idx_r <= 3'h0;
                        shf_r <= byte_first;
                        sda_oe_r <= ~byte_first[7];
                        cnt_r <= 4'h1;
                    end
                end
                psf_pkg::DS_SEND: begin
                    if (scl_fall) begin
                        if (cnt_r == 4'h8) begin
                            st_r <= psf_pkg::DS_MACK;
                            sda_oe_r <= 1'b0;
                        end else begin
                            shf_r <= {shf_r[6:0], 1'b0};
                            sda_oe_r <= ~shf_r[6];
                            cnt_r <= cnt_r + 4'h1;
                        end
                    end
                end
                psf_pkg::DS_MACK: begin
                    if (scl_rise) begin
                        ackd_r <= ~sda_f;
                    end else if (scl_fall) begin
                        if (ackd_r) begin
                            // bytes past the fourth read as zero
                            st_r <= psf_pkg::DS_SEND;
                            idx_r <= idx_nxt;
                            shf_r <= byte_next;
                            sda_oe_r <= ~byte_next[7];
                            cnt_r <= 4'h1;
                        end else begin
                            st_r <= psf_pkg::DS_IDLE;
                        end
                    end
                end
                default: begin
                    st_r <= psf_pkg::DS_IDLE;
                end
            endcase
        end
    end
endmodule : psf_dev
`default_nettype wire

// File: core/psf_host.sv
// host end: drives scl and fetches packets of a chosen length
`timescale 1ns/1ps
`default_nettype none
module psf_host #(
    parameter logic [6:0] ADDR = psf_pkg::TGT_ADDR,
    parameter int QTR = psf_pkg::QTR_CYC,
    parameter int FREE = psf_pkg::BUF_CYC,
    parameter int RX_DEPTH = 2
) (
    input wire logic mclk_i,
    input wire logic sys_rst_i,
    input wire logic req_valid_i,
    input wire logic [2:0] req_len_i,
    output logic req_ready_o,
    output logic rx_valid_o,
    output logic [7:0] rx_data_o,
    input wire logic rx_ready_i,
    output logic done_o,
    output logic nak_o,
    psf_link_if.host link
);

    // ****************************************************************
    // sampling and timing
    // ****************************************************************
    psf_pkg::psf_host_state_type st_r;
    logic [2:0] sda_s_r;
    logic sda_f_r;
    logic [15:0] qc_r;
    logic [15:0] wt_r;

    wire sda_f = psf_pkg::filt(sda_s_r[1], sda_s_r[2], sda_f_r);
    wire tick = (qc_r == 16'(QTR - 1));

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            sda_s_r <= 3'h7;
            sda_f_r <= 1'b1;
            qc_r <= 16'h0000;
        end else begin
            sda_s_r <= {sda_s_r[1:0], link.sda};
            sda_f_r <= sda_f;
            qc_r <= tick ? 16'h0000 : qc_r + 16'h0001;
        end
    end

    // ****************************************************************
    // receive buffer
    // ****************************************************************
    logic [8:0] rx_r;
    logic buf_rdy;
    wire push = (st_r == psf_pkg::HS_HOLD) & buf_rdy;

    // a full buffer holds scl low instead of dropping a byte
    psf_buf #(
        .W(8),
        .D(RX_DEPTH)
    ) u_rx (
        .mclk_i(mclk_i),
        .sys_rst_i(sys_rst_i),
        .in_valid_i(push),
        .in_data_i(rx_r[8:1]),
        .in_ready_o(buf_rdy),
        .out_valid_o(rx_valid_o),
        .out_data_o(rx_data_o),
        .out_ready_i(rx_ready_i)
    );

    // ****************************************************************
    // bit engine
    // ****************************************************************
    logic [1:0] ph_r;
    logic [3:0] bit_r;
    logic [8:0] tx_r;
    logic afr_r;
    logic [2:0] rem_r;
    logic scl_oe_r;
    logic sda_oe_r;

    // data frame: released byte, then ack unless this is the last one
    function automatic logic [8:0] dframe(input logic [2:0] rem);
        dframe = {8'hFF, (rem <= 3'h1)};
    endfunction : dframe

    assign link.scl_o = 1'b0;
    assign link.scl_oe = scl_oe_r;
    assign link.h_sda_o = 1'b0;
    assign link.h_sda_oe = sda_oe_r;

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            st_r <= psf_pkg::HS_IDLE;
            ph_r <= 2'h0;
            bit_r <= 4'h0;
            tx_r <= 9'h1FF;
            rx_r <= 9'h000;
            afr_r <= 1'b0;
            rem_r <= 3'h0;
            scl_oe_r <= 1'b0;
            sda_oe_r <= 1'b0;
            req_ready_o <= 1'b1;
            done_o <= 1'b0;
            nak_o <= 1'b0;
            wt_r <= 16'h0000;
        end else begin
            done_o <= 1'b0;
            nak_o <= 1'b0;
            unique case (st_r)
                psf_pkg::HS_IDLE: begin
                    if (req_valid_i) begin
                        st_r <= psf_pkg::HS_START;
                        rem_r <= (req_len_i == 3'h0) ? 3'h1 : req_len_i;
                        req_ready_o <= 1'b0;
                    end
                end
                psf_pkg::HS_START: begin
                    if (tick && !sda_oe_r) begin
                        sda_oe_r <= 1'b1;
                    end else if (tick) begin
                        // sda stays low into a leading zero address bit
                        scl_oe_r <= 1'b1;
                        st_r <= psf_pkg::HS_BITS;
                        ph_r <= 2'h0;
                        bit_r <= 4'h0;
                        tx_r <= {ADDR, 1'b1, 1'b1};
                        afr_r <= 1'b1;
                    end
                end
                psf_pkg::HS_BITS: begin
                    if (tick) begin
                        ph_r <= ph_r + 2'h1;
                        unique case (ph_r)
                            2'h0: sda_oe_r <= ~tx_r[8];
                            2'h1: scl_oe_r <= 1'b0;
                            2'h2: rx_r <= {rx_r[7:0], sda_f};
                            2'h3: begin
                                scl_oe_r <= 1'b1;
                                tx_r <= {tx_r[7:0], 1'b1};
                                bit_r <= bit_r + 4'h1;
                                if (bit_r == 4'(psf_pkg::BITS_PER_FRAME - 1)) begin
                                    bit_r <= 4'h0;
                                    if (afr_r && rx_r[0]) begin
                                        nak_o <= 1'b1;
                                        st_r <= psf_pkg::HS_STOP;
                                    end else if (afr_r) begin
                                        afr_r <= 1'b0;
                                        tx_r <= dframe(rem_r);
                                    end else begin
                                        st_r <= psf_pkg::HS_HOLD;
                                    end
                                end
                            end
                        endcase
                    end
                end
                psf_pkg::HS_HOLD: begin
                    sda_oe_r <= 1'b0;
                    if (buf_rdy) begin
                        if (rem_r <= 3'h1) begin
                            st_r <= psf_pkg::HS_STOP;
                        end else begin
                            rem_r <= rem_r - 3'h1;
                            tx_r <= dframe(rem_r - 3'h1);
                            st_r <= psf_pkg::HS_BITS;
                        end
                    end
                end
                psf_pkg::HS_STOP: begin
                    // clocks always run before stop, so no bare start-stop
                    if (tick) begin
                        ph_r <= ph_r + 2'h1;
                        unique case (ph_r)
                            2'h0: sda_oe_r <= 1'b1;
                            2'h1: scl_oe_r <= 1'b0;
                            2'h2: sda_oe_r <= 1'b0;
                            2'h3: begin
                                st_r <= psf_pkg::HS_FREE;
                                done_o <= 1'b1;
                                wt_r <= 16'h0000;
                            end
                        endcase
                    end
                end
                psf_pkg::HS_FREE: begin
                    wt_r <= wt_r + 16'h0001;
                    if (wt_r == 16'(FREE - 1)) begin
                        st_r <= psf_pkg::HS_IDLE;
                        req_ready_o <= 1'b1;
                    end
                end
                default: begin
                    st_r <= psf_pkg::HS_IDLE;
                end
            endcase
        end
    end
endmodule : psf_host
`default_nettype wire

// File: tb/psf_asserts.sv
// concurrent checks on the two-wire fetch link
`timescale 1ns/1ps
`default_nettype none
module psf_asserts (
    input wire logic mclk_i,
    input wire logic sys_rst_i,
    input wire logic scl,
    input wire logic sda,
    input wire logic d_sda_oe
);
    default clocking @(posedge mclk_i); endclocking
    default disable iff (sys_rst_i);
    sequence s_start;
        scl && $past(scl) && $fell(sda);
    endsequence
    sequence s_stop;
        scl && $past(scl) && $rose(sda);
    endsequence
    property p_dev_hold; scl && $past(scl) |-> $stable(d_sda_oe); endproperty
    a_dev_hold: assert property (p_dev_hold)
        else $error("device moved sda while scl high");
    property p_dev_setup; $changed(d_sda_oe) |-> !scl; endproperty
    a_dev_setup: assert property (p_dev_setup)
        else $error("device changed sda outside scl low");
    property p_start_hold; s_start |=> !$fell(sda) until $rose(scl); endproperty
    a_start_hold: assert property (p_start_hold)
        else $error("sda fell before first scl rise");
    property p_first_clk; s_start |-> ##[1:40] $rose(scl); endproperty
    a_first_clk: assert property (p_first_clk)
        else $error("no scl rise after start");
    property p_no_restart;
        s_start |=> !(scl && $fell(sda)) until (scl && $rose(sda));
    endproperty
    a_no_restart: assert property (p_no_restart)
        else $error("repeated start inside a transfer");
    property p_ends; s_start |-> ##[1:1000] s_stop; endproperty
    a_ends: assert property (p_ends)
        else $error("transfer never stopped");
    property p_free; s_stop |=> (scl && sda)[*2]; endproperty
    a_free: assert property (p_free)
        else $error("bus not left free after stop");
    property p_no_bare_stop; s_start |=> !(scl && $rose(sda)) until !scl;
    endproperty
    a_no_bare_stop: assert property (p_no_bare_stop)
        else $error("stop right after start");
endmodule : psf_asserts
`default_nettype wire

// File: tb/test_pressure_sensor_i2c_fetch.sv
// self-checking bench for both ends of the fetch link
`timescale 1ns/1ps
`default_nettype none
module test_pressure_sensor_i2c_fetch;
    logic mclk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic mv = 1'b0, cm = 1'b0, rv = 1'b0, rr = 1'b1, n2 = 1'b0;
    logic [13:0] mp = 14'h0000;
    logic [10:0] mt = 11'h000;
    logic [3:0] mf = 4'h0;
    logic [2:0] rl = 3'h1;
    logic [31:0] seed = 32'h000128CA;
    logic mr, diag, lerr, done, nak, nak2, rxv, rq;
    logic [7:0] rxd;
    logic [7:0] q[$];
    int num_errors = 0, check_count = 0;
    psf_link_if lk ();
    psf_link_if lk2 ();
    psf_dev i_psf_dev (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i),
        .meas_valid_i(mv), .meas_pressure_i(mp), .meas_temp_i(mt),
        .meas_fault_i(mf), .meas_ready_o(mr), .cmd_mode_i(cm),
        .diag_o(diag), .link_err_o(lerr), .link(lk.dev));
    psf_host #(.QTR(4), .FREE(2)) i_psf_host (.mclk_i(mclk_i),
        .sys_rst_i(sys_rst_i), .req_valid_i(rv), .req_len_i(rl),
        .req_ready_o(rq), .rx_valid_o(rxv), .rx_data_o(rxd), .rx_ready_i(rr),
        .done_o(done), .nak_o(nak), .link(lk.host));
    // second link: host asks a foreign address
    psf_dev i_psf_dev_2 (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i),
        .meas_valid_i(mv), .meas_pressure_i(mp), .meas_temp_i(mt),
        .meas_fault_i(mf), .meas_ready_o(), .cmd_mode_i(cm),
        .diag_o(), .link_err_o(), .link(lk2.dev));
    psf_host #(.ADDR(7'h29), .QTR(4), .FREE(2)) i_psf_host_2 (
        .mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .req_valid_i(rv),
        .req_len_i(rl), .req_ready_o(), .rx_valid_o(), .rx_data_o(),
        .rx_ready_i(rr), .done_o(), .nak_o(nak2), .link(lk2.host));
    psf_asserts i_psf_asserts (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i),
        .scl(lk.scl), .sda(lk.sda), .d_sda_oe(lk.d_sda_oe));
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd
    function automatic logic [7:0] exp_b(input int i, input logic [1:0] s,
                                         input logic [13:0] p,
                                         input logic [10:0] t);
        logic [39:0] pk;
        pk = {s, p, t, 13'h0000};
        return (i < 5) ? pk[39 - 8 * i -: 8] : 8'h00;
    endfunction : exp_b
    task automatic chk(input logic ok, input string m);
        check_count++;
        if (ok !== 1'b1) begin
            num_errors++;
            $display("FAIL %0t %s", $time, m);
        end
    endtask : chk
    task automatic conclude();
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : conclude
    task automatic meas(input logic [3:0] f);
        logic [31:0] r;
        r = rnd();
        mp <= r[13:0];
        mt <= r[26:16];
        mf <= f;
        mv <= 1'b1;
        @(posedge mclk_i);
        mv <= 1'b0;
        repeat (4) @(posedge mclk_i);
    endtask : meas
    task automatic fetch(input int n, input logic [1:0] s);
        int k;
        k = 0;
        repeat (8) @(posedge mclk_i);
        rl <= n[2:0];
        rv <= 1'b1;
        @(posedge mclk_i);
        rv <= 1'b0;
        while (done !== 1'b1 && k < 3000) begin
            @(posedge mclk_i);
            k++;
        end
        repeat (20) @(posedge mclk_i);
        chk(q.size() == n && k < 3000, "byte count");
        foreach (q[i]) chk(q[i] === exp_b(i, s, mp, mt), "byte");
        chk(n2 === 1'b1, "foreign address answered");
        chk(lerr === 1'b0, "link error raised");
        chk(rq === 1'b1, "host not ready after stop");
        q.delete();
        n2 <= 1'b0;
    endtask : fetch
    always #4 mclk_i = ~mclk_i;
    // random rx stalls keep the host's buffer under pressure
    always @(posedge mclk_i) begin
        if (rxv === 1'b1 && rr) q.push_back(rxd);
        if (nak2 === 1'b1) n2 <= 1'b1;
        if (nak !== 1'b0 && !sys_rst_i) chk(1'b0, "own address refused");
        rr <= (rnd() % 4) != 0;
    end
    initial begin
        #400000;
        chk(1'b0, "watchdog");
        conclude();
    end
    initial begin
        repeat (16) @(posedge mclk_i);
        sys_rst_i <= 1'b0;
        fetch(2, 2'h2);
        meas(4'h0);
        fetch(4, 2'h0);
        fetch(3, 2'h2);
        cm <= 1'b1;
        meas(4'h0);
        fetch(1, 2'h1);
        cm <= 1'b0;
        repeat (5) begin
            meas(4'h0);
            fetch(rnd() % 5 + 1, 2'h0);
        end
        meas(4'h0);
        fork
            fetch(5, 2'h0);
        join_none
        // device only drains its queue between transfers
        repeat (60) @(posedge mclk_i);
        mv <= 1'b1;
        repeat (6) @(posedge mclk_i);
        chk(mr === 1'b0, "queue never refused");
        mv <= 1'b0;
        wait fork;
        fetch(2, 2'h0);
        meas(4'h1 << (rnd() % 4));
        fetch(2, 2'h3);
        meas(4'h0);
        fetch(4, 2'h3);
        chk(diag === 1'b1, "diag dropped");
        sys_rst_i <= 1'b1;
        mp <= 14'h0000;
        mt <= 11'h000;
        repeat (16) @(posedge mclk_i);
        sys_rst_i <= 1'b0;
        chk(diag === 1'b0, "diag kept over reset");
        fetch(2, 2'h2);
        conclude();
    end
endmodule : test_pressure_sensor_i2c_fetch
`default_nettype wire
